/* stc_clk_source.sv */
// Model of the external clock source: pin or shared oscillator
`timescale 1ns/100ps
`default_nettype none
module stc_clk_source #(
  parameter int HALF = 3
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // Burst request
  input  wire logic       go,
  input  wire logic [3:0] pulses,
  // Pin side
  output logic            pin,
  output logic            busy
);
  logic [3:0] left;
  int         k;

  // Pin rests low between bursts; a real source stands still there too
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin  <= 1'b0;
      busy <= 1'b0;
      left <= 4'h0;
      k    <= 0;
    end else if (!busy && go) begin
      busy <= 1'b1;
      left <= pulses;
      k    <= 0;
    end else if (busy) begin
      if (k == HALF - 1) begin
        k <= 0;
        pin <= !pin;
        if (pin) begin
          left <= left - 4'h1;
          busy <= (left != 4'h1);
        end
      end else begin
        k <= k + 1;
      end
    end
  end
endmodule
`default_nettype wire

/* stc_edge_sync.sv */
// Two-flop synchroniser with edge detection for one pin
`timescale 1ns/100ps
`default_nettype none
module stc_edge_sync
  import stc_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // Pin and results
  input  wire logic din,
  output logic      level,
  output logic      rise,
  output logic      fall
);

  stc_sync_state_t st;
  stc_sync_state_t n;

  always_comb begin
    n    = st;
    n.s1 = din;
    n.s2 = st.s1;
    n.s3 = st.s2;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= n;
    end
  end

  // First stage is read by the second stage only
  assign level = st.s2;
  assign rise  = st.s2 & ~st.s3;
  assign fall  = ~st.s2 & st.s3;

endmodule
`default_nettype wire

/* stc_pkg.sv */
// Constants, field layouts and state types of the sixteen-bit timer/counter
package stc_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_LOW     = 8'h04;
  localparam logic [7:0] ADDR_HIGH    = 8'h08;
  localparam logic [7:0] ADDR_FLAGS   = 8'h0c;
  localparam logic [7:0] ADDR_ENABLES = 8'h10;
  localparam logic [7:0] ADDR_SIBLING = 8'h14;
  localparam logic [7:0] ADDR_PORT    = 8'h18;
  localparam logic [7:0] ADDR_PINS    = 8'h1c;

  // Field positions
  localparam int OVF_BIT      = 1;
  localparam int OSC_EN_BIT   = 3;
  localparam int PORT_DIR_LSB = 0;
  localparam int PORT_OUT_LSB = 4;

  // Reset values and counter maximum
  localparam logic [7:0]  CTRL_RESET  = 8'h00;
  localparam logic [1:0]  DIR_RESET   = 2'h3;
  localparam logic [1:0]  OUT_RESET   = 2'h0;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_MAX   = 16'hffff;

  // Compare unit mode that fires the special event trigger
  localparam logic [3:0] SPECIAL_TRIGGER_MODE = 4'hb;

  // Instruction clock is the system clock divided by this
  localparam int         INT_CLK_DIV    = 4;
  localparam logic [1:0] INT_PHASE_LAST = 2'(INT_CLK_DIV - 1);

  // Units that take the second timer pair, one bit per unit
  localparam logic [4:0] CCP_MAP_00 = 5'h00;
  localparam logic [4:0] CCP_MAP_01 = 5'h1e;
  localparam logic [4:0] CCP_MAP_10 = 5'h1c;
  localparam logic [4:0] CCP_MAP_11 = 5'h1f;

  typedef struct packed {
    logic       wideAccessEnable;
    logic       ccpSourceSelHi;
    logic [1:0] prescaleSel;
    logic       ccpSourceSelLo;
    logic       extSyncDisable;
    logic       clockSourceSel;
    logic       countRun;
  } stc_ctrl_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } stc_sync_state_t;

  typedef struct packed {
    logic [2:0] cnt;
  } stc_presc_state_t;

  typedef struct packed {
    stc_ctrl_t   ctrl;
    logic [15:0] count;
    logic [7:0]  highBuf;
    logic        ovfFlag;
    logic        ovfEnable;
    logic        oscEnable;
    logic [1:0]  portDir;
    logic [1:0]  portOut;
    logic [1:0]  pinOe;
    logic [1:0]  intPhase;
    logic        armed;
    logic        syncPulse;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic [4:0]  ccpUseSecond;
  } stc_top_state_t;

endpackage

/* stc_prescaler.sv */
// Input prescaler dividing a tick stream by 1, 2, 4 or 8
`timescale 1ns/100ps
`default_nettype none
module stc_prescaler
  import stc_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // Control
  input  wire logic       clear,
  input  wire logic [1:0] sel,
  // Ticks
  input  wire logic       tickIn,
  output logic            tickOut
);

  stc_presc_state_t st;
  stc_presc_state_t n;
  logic [2:0]       limit;

  assign limit   = 3'((4'h1 << sel) - 4'h1);
  assign tickOut = tickIn & (st.cnt == limit);

  always_comb begin
    n = st;
    if (clear) begin
      n.cnt = 3'h0;
    end else if (tickIn) begin
      n.cnt = (st.cnt == limit) ? 3'h0 : 3'(st.cnt + 3'h1);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= n;
    end
  end

endmodule
`default_nettype wire

/* stc_timer_top.sv */
// Sixteen-bit timer/counter with APB registers and overflow interrupt
`timescale 1ns/100ps
`default_nettype none
module stc_timer_top
  import stc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Compare unit
  input  wire logic        ccpTrigger,
  input  wire logic [3:0]  ccpMode,
  output logic [4:0]       ccpUseSecond,
  // Pins
  input  wire logic        extClockPin,
  input  wire logic        oscInPinIn,
  output logic             oscInPinOut,
  output logic             oscInPinOe,
  input  wire logic        oscOutPinIn,
  output logic             oscOutPinOut,
  output logic             oscOutPinOe,
  // Status
  output logic             oscRun,
  output logic [15:0]      countValue,
  output logic             irq
);

  logic [1:0]     rstPipe;
  logic           rstSync_b;
  stc_top_state_t st;
  stc_top_state_t n;
  logic [2:0]     pinsIn;
  logic [2:0]     pinLevel;
  logic [2:0]     pinRise;
  logic [2:0]     pinFall;
  logic           setup;
  logic           done;
  logic           wr;
  logic           lowWr;
  logic           highWr;
  logic           cntWr;
  logic           trigClr;
  logic           intTick;
  logic           extRise;
  logic           extFall;
  logic           extPulseUnsync;
  logic           extTick;
  logic           srcTick;
  logic           incTick;
  logic           wide;
  logic [7:0]     rdByte;
  logic           mapped;

  // Reset release through two flops
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rstPipe <= 2'h0;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end
  assign rstSync_b = rstPipe[1];

  // Every pin passes two flops before any logic reads it
  assign pinsIn = {oscOutPinIn, oscInPinIn, extClockPin};
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_pin
      stc_edge_sync u_sync (
        .clk   (clk),
        .rst_b (rstSync_b),
        .din   (pinsIn[gi]),
        .level (pinLevel[gi]),
        .rise  (pinRise[gi]),
        .fall  (pinFall[gi])
      );
    end
  endgenerate

  // Bus decode; a write acts only at the completing edge
  assign setup  = psel & ~penable;
  assign done   = psel & penable & st.pready;
  assign wr     = done & pwrite;
  assign lowWr  = wr & (paddr == ADDR_LOW);
  assign highWr = wr & (paddr == ADDR_HIGH);
  assign wide   = st.ctrl.wideAccessEnable;
  assign cntWr  = lowWr | (highWr & ~wide);

  // Compare trigger, only in special event mode
  assign trigClr = ccpTrigger & (ccpMode == SPECIAL_TRIGGER_MODE);

  // Clock sources
  assign intTick = (st.intPhase == INT_PHASE_LAST);
  assign extRise = st.oscEnable ? pinRise[1] : pinRise[0];
  assign extFall = st.oscEnable ? pinFall[1] : pinFall[0];
  assign extPulseUnsync = extRise & st.armed;
  // Direct path saves one cycle; pins are still flopped for safety
  assign extTick = st.ctrl.extSyncDisable ? extPulseUnsync
                                          : st.syncPulse;
  assign srcTick = st.ctrl.countRun &
                   (st.ctrl.clockSourceSel ? extTick : intTick);

  stc_prescaler u_presc (
    .clk     (clk),
    .rst_b   (rstSync_b),
    .clear   (lowWr),
    .sel     (st.ctrl.prescaleSel),
    .tickIn  (srcTick),
    .tickOut (incTick)
  );

  // Read mux
  always_comb begin
    rdByte = 8'h00;
    mapped = 1'b1;
    case (paddr)
      ADDR_CTRL:    rdByte = st.ctrl;
      ADDR_LOW:     rdByte = st.count[7:0];
      ADDR_HIGH:    rdByte = wide ? st.highBuf : st.count[15:8];
      ADDR_FLAGS:   rdByte[OVF_BIT] = st.ovfFlag;
      ADDR_ENABLES: rdByte[OVF_BIT] = st.ovfEnable;
      ADDR_SIBLING: rdByte[OSC_EN_BIT] = st.oscEnable;
      ADDR_PORT: begin
        rdByte[PORT_DIR_LSB +: 2] = st.portDir;
        rdByte[PORT_OUT_LSB +: 2] = st.portOut;
      end
      ADDR_PINS:    rdByte[1:0] = st.oscEnable ? 2'h0 : pinLevel[2:1];
      default:      mapped = 1'b0;
    endcase
  end

  always_comb begin
    n = st;
    n.intPhase = 2'(st.intPhase + 2'h1);
    // Bus answer one cycle after setup
    n.pready = setup;
    if (setup) begin
      n.prdata  = pwrite ? 32'h0000_0000 : {24'h00_0000, rdByte};
      n.pslverr = ~mapped;
      // Snapshot taken with the low byte so both halves match
      if (!pwrite && wide && paddr == ADDR_LOW) begin
        n.highBuf = st.count[15:8];
      end
    end
    // Control and side registers
    if (wr && paddr == ADDR_CTRL) begin
      n.ctrl = stc_ctrl_t'(pwdata[7:0]);
    end
    if (wr && paddr == ADDR_ENABLES) begin
      n.ovfEnable = pwdata[OVF_BIT];
    end
    if (wr && paddr == ADDR_SIBLING) begin
      n.oscEnable = pwdata[OSC_EN_BIT];
    end
    if (wr && paddr == ADDR_PORT) begin
      n.portDir = pwdata[PORT_DIR_LSB +: 2];
      n.portOut = pwdata[PORT_OUT_LSB +: 2];
    end
    // Edge arming for the external source
    if (!st.ctrl.clockSourceSel || !st.ctrl.countRun) begin
      n.armed = 1'b0;
    end else if (extFall) begin
      n.armed = 1'b1;
    end
    n.syncPulse = extPulseUnsync;
    // Counter: write beats trigger, trigger beats increment
    if (highWr && wide) begin
      n.highBuf = pwdata[7:0];
    end
    if (lowWr) begin
      n.count = {wide ? st.highBuf : st.count[15:8], pwdata[7:0]};
    end else if (highWr && !wide) begin
      n.count[15:8] = pwdata[7:0];
    end else if (trigClr) begin
      n.count = COUNT_RESET;
    end else if (incTick) begin
      n.count = st.count + 16'h0001;
    end
    // Write-one clears the flag; a same-cycle overflow still sets it
    if (wr && paddr == ADDR_FLAGS && pwdata[OVF_BIT]) begin
      n.ovfFlag = 1'b0;
    end
    if (!cntWr && !trigClr && incTick && st.count == COUNT_MAX) begin
      n.ovfFlag = 1'b1;
    end
    n.irq = n.ovfFlag & n.ovfEnable;
    n.pinOe = n.oscEnable ? 2'h0 : ~n.portDir;
    case ({n.ctrl.ccpSourceSelHi, n.ctrl.ccpSourceSelLo})
      2'h0:    n.ccpUseSecond = CCP_MAP_00;
      2'h1:    n.ccpUseSecond = CCP_MAP_01;
      2'h2:    n.ccpUseSecond = CCP_MAP_10;
      default: n.ccpUseSecond = CCP_MAP_11;
    endcase
  end

  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      st              <= '0;
      st.ctrl         <= stc_ctrl_t'(CTRL_RESET);
      st.count        <= COUNT_RESET;
      st.portDir      <= DIR_RESET;
      st.portOut      <= OUT_RESET;
      st.ccpUseSecond <= CCP_MAP_00;
    end else begin
      st <= n;
    end
  end

  assign prdata       = st.prdata;
  assign pready       = st.pready;
  assign pslverr      = st.pslverr;
  assign ccpUseSecond = st.ccpUseSecond;
  assign oscInPinOut  = st.portOut[0];
  assign oscOutPinOut = st.portOut[1];
  assign oscInPinOe   = st.pinOe[0];
  assign oscOutPinOe  = st.pinOe[1];
  assign oscRun       = st.oscEnable;
  assign countValue   = st.count;
  assign irq          = st.irq;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstSync_b);

  sequence s_intGap;
    !intTick [*3] ##1 intTick;
  endsequence

  a_count_step: assert property (
    incTick && !cntWr && !trigClr |=>
      st.count == 16'($past(st.count) + 16'h0001))
    else $error("counter did not step by one");

  a_wrap_flag: assert property (
    incTick && !cntWr && !trigClr && st.count == COUNT_MAX |=>
      st.count == COUNT_RESET && st.ovfFlag)
    else $error("wrap did not clear count and set flag");

  a_irq_gate: assert property (
    incTick && !cntWr && !trigClr && st.count == COUNT_MAX |=>
      st.ovfFlag && irq == st.ovfEnable)
    else $error("interrupt does not follow flag and enable");

  a_int_rate: assert property (
    intTick |=> s_intGap)
    else $error("internal tick not every four clocks");

  a_stop_hold: assert property (
    !st.ctrl.countRun && !cntWr && !trigClr |=>
      $stable(st.count))
    else $error("stopped counter changed");

  a_trig_clear: assert property (
    trigClr && !cntWr |=> st.count == COUNT_RESET &&
      !$rose(st.ovfFlag))
    else $error("trigger did not clear quietly");

  a_write_wins: assert property (
    trigClr && lowWr && !wide |=>
      st.count[7:0] == $past(pwdata[7:0]))
    else $error("trigger beat a counter write");

  a_osc_pins: assert property (
    st.oscEnable |-> !oscInPinOe && !oscOutPinOe)
    else $error("oscillator pins driven");

  a_ccp_map: assert property (
    st.ctrl.ccpSourceSelHi && st.ctrl.ccpSourceSelLo |->
      ccpUseSecond == CCP_MAP_11)
    else $error("compare unit map wrong");

endmodule
`default_nettype wire

/* stc_timer_top_tb.sv */
// Self-checking bench for the sixteen-bit timer/counter
`timescale 1ns/100ps
`default_nettype none
module stc_timer_top_tb import stc_pkg::*; ;
  logic        clk, rst_b, psel, penable, pwrite, ccpTrigger, go, er;
  logic        pready, pslverr, oscInPinOut, oscInPinOe, oscOutPinOut;
  logic        oscOutPinOe, oscRun, irq, srcPin, srcBusy, useOsc;
  logic        pinLvl, oscOutPinIn;
  logic [3:0]  ccpMode, np;
  logic [4:0]  ccpUseSecond;
  logic [7:0]  paddr;
  logic [15:0] countValue, hv;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  csel [4] = '{8'h00, 8'h08, 8'h40, 8'h48};
  logic [4:0]  cexp [4] = '{5'h00, 5'h1e, 5'h1c, 5'h1f};
  int          errCount, nTests, n, p;
  wire logic   extClockPin = useOsc ? 1'b0 : srcPin;
  wire logic   oscInPinIn  = useOsc ? srcPin : pinLvl;

  stc_timer_top u_dut (.clk(clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ccpTrigger(ccpTrigger), .ccpMode(ccpMode),
    .ccpUseSecond(ccpUseSecond), .extClockPin(extClockPin),
    .oscInPinIn(oscInPinIn), .oscInPinOut(oscInPinOut),
    .oscInPinOe(oscInPinOe), .oscOutPinIn(oscOutPinIn),
    .oscOutPinOut(oscOutPinOut), .oscOutPinOe(oscOutPinOe),
    .oscRun(oscRun), .countValue(countValue), .irq(irq));

  stc_clk_source u_src (.clk(clk), .rst_b(rst_b), .go(go), .pulses(np),
    .pin(srcPin), .busy(srcBusy));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic testDone();
    $display("checks %0d mismatches %0d", nTests, errCount);
    if (errCount == 0 && nTests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] got,
                       input logic [31:0] exp);
    nTests++;
    if (got !== exp) begin
      errCount++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // A spent wait bound ends the run at once
  task automatic bound(input int k, input int lim);
    if (k >= lim) begin
      errCount++;
      testDone();
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int i;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    bound(i, 20);
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                     input string nm);
    apb(1'b0, a, 32'h0);
    check(nm, rd, e);
  endtask

  // Cycles until the counter next moves
  task automatic gap(output int k);
    logic [15:0] v;
    v = countValue;
    k = 0;
    while (countValue === v && k < 300) begin
      @(posedge clk);
      k++;
    end
    bound(k, 300);
  endtask

  task automatic burst(input logic [3:0] cnt);
    int i;
    np <= cnt;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    for (i = 0; i < 300 && srcBusy; i++) @(posedge clk);
    bound(i, 300);
    repeat (8) @(posedge clk);
  endtask

  initial begin
    #1000000;
    errCount++;
    testDone();
  end

  initial begin
    {rst_b, psel, penable, pwrite, ccpTrigger, go, useOsc} = 7'h0;
    {paddr, pwdata, ccpMode, np} = 48'h0;
    pinLvl = 1'b1;
    oscOutPinIn = 1'b1;
    errCount = 0;
    nTests = 0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    check("count", countValue, 16'h0000);
    rdc(ADDR_CTRL, 32'h0, "ctrl");
    rdc(ADDR_PORT, 32'h3, "port");
    apb(1'b0, 8'h20, 32'h0);
    check("slverr", er, 1'b1);
    for (n = 0; n < 4; n++) begin
      wr(ADDR_CTRL, csel[n]);
      check("ccp", ccpUseSecond, cexp[n]);
      rdc(ADDR_CTRL, csel[n], "ctrlrw");
    end
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_LOW, 8'hfe);
    wr(ADDR_HIGH, 8'hff);
    check("bytes", countValue, 16'hfffe);
    wr(ADDR_ENABLES, 8'h02);
    wr(ADDR_CTRL, 8'h01);
    for (n = 0; n < 50 && irq !== 1'b1; n++) @(posedge clk);
    bound(n, 50);
    check("wrap", countValue, 16'h0000);
    wr(ADDR_CTRL, 8'h00);
    rdc(ADDR_FLAGS, 8'h02, "flag");
    wr(ADDR_FLAGS, 8'h02);
    rdc(ADDR_FLAGS, 8'h00, "flagclr");
    check("irqclr", irq, 1'b0);
    // Masked overflow still latches the flag
    wr(ADDR_ENABLES, 8'h00);
    wr(ADDR_LOW, 8'hfe);
    wr(ADDR_HIGH, 8'hff);
    wr(ADDR_CTRL, 8'h01);
    repeat (40) @(posedge clk);
    check("masked", irq, 1'b0);
    wr(ADDR_CTRL, 8'h00);
    rdc(ADDR_FLAGS, 8'h02, "flagm");
    wr(ADDR_ENABLES, 8'h02);
    check("unmask", irq, 1'b1);
    wr(ADDR_FLAGS, 8'h02);
    for (p = 0; p < 4; p++) begin
      wr(ADDR_CTRL, 8'(8'h01 | (p << 4)));
      gap(n);
      gap(n);
      check("rate", n, 4 << p);
    end
    wr(ADDR_CTRL, 8'h00);
    hv = countValue;
    repeat (20) @(posedge clk);
    check("hold", countValue, hv);
    wr(ADDR_LOW, 8'h55);
    wr(ADDR_HIGH, 8'h00);
    ccpMode <= 4'h3;
    ccpTrigger <= 1'b1;
    @(posedge clk);
    ccpTrigger <= 1'b0;
    @(posedge clk);
    check("trgmode", countValue, 16'h0055);
    ccpMode <= 4'hb;
    ccpTrigger <= 1'b1;
    @(posedge clk);
    ccpTrigger <= 1'b0;
    @(posedge clk);
    check("trg", countValue, 16'h0000);
    // Trigger held across a low write: the write must land first
    ccpTrigger <= 1'b1;
    wr(ADDR_LOW, 8'h77);
    ccpTrigger <= 1'b0;
    rdc(ADDR_FLAGS, 8'h00, "trgflag");
    wr(ADDR_CTRL, 8'h80);
    wr(ADDR_HIGH, 8'h12);
    check("widehi", countValue, 16'h0000);
    wr(ADDR_LOW, 8'h34);
    check("wide", countValue, 16'h1234);
    rdc(ADDR_LOW, 8'h34, "rdlo");
    rdc(ADDR_HIGH, 8'h12, "rdhi");
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_HIGH, 8'h56);
    check("bytehi", countValue, 16'h5634);
    // First rising edge is ignored and the falling edge after it arms, so n pulses give n-1 counts
    for (p = 0; p < 2; p++) begin
      wr(ADDR_CTRL, 8'h00);
      wr(ADDR_LOW, 8'h00);
      wr(ADDR_HIGH, 8'h00);
      wr(ADDR_CTRL, 8'(8'h03 | (p << 2)));
      burst(4'h5);
      check("ext", countValue, 16'h0004);
    end
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_LOW, 8'h00);
    wr(ADDR_PORT, 8'h30);
    check("oe", {oscOutPinOe, oscInPinOe}, 2'b11);
    check("pout", {oscOutPinOut, oscInPinOut}, 2'b11);
    rdc(ADDR_PINS, 8'h03, "pins");
    // Switch the pin while unarmed, so its falling edge cannot arm counting
    useOsc <= 1'b1;
    wr(ADDR_SIBLING, 8'h08);
    check("osc", oscRun, 1'b1);
    check("oeosc", {oscOutPinOe, oscInPinOe}, 2'b00);
    rdc(ADDR_PINS, 8'h00, "pinsosc");
    wr(ADDR_CTRL, 8'h03);
    burst(4'h3);
    check("osccnt", countValue, 16'h0002);
    wr(ADDR_SIBLING, 8'h00);
    check("oscoff", oscRun, 1'b0);
    testDone();
  end
endmodule
`default_nettype wire
